// File: tag_host_buffer.sv
// tag_host_buffer: shared message buffer, interrupt registers, eeprom arbitration and pull control
// assumes a classic wishbone master, an rf framing engine and an eeprom controller on clk
`timescale 1ns/1ps

module tag_host_buffer (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [31:0] wbAdrI,
   input wire logic [31:0] wbDatI,
   output logic [31:0] wbDatO,
   input wire logic wbWeI,
   input wire logic [3:0] wbSelI,
   input wire logic wbCycI,
   input wire logic wbStbI,
   output logic wbAckO,
   input wire logic [7:0] factory_config_word,
   input wire logic selectN,
   output logic strongPullEn,
   output logic weakPullEn,
   output logic irqOut,
   input wire tag_exchange_pkg::rf_rx_t rfRx,
   input wire logic rfTxReady,
   output logic rfTxValid,
   output logic [8:0] rfTxData,
   input wire logic rfEeReq,
   input wire logic rfEeWrite,
   output logic rfEeGrant,
   output logic eeReq,
   output logic eeWrite,
   output logic [tag_exchange_pkg::EE_ADDR_W-1:0] eeAddr,
   output logic [31:0] eeWData,
   input wire tag_exchange_pkg::ee_status_t eeStat
);
   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   logic bufRdPend_reg;
   // the wait cycle of a buffer read is masked so the byte is popped only once
   wire busReq = wbCycI && wbStbI && !wbAckO && !bufRdPend_reg;
   wire [7:0] regOff = wbAdrI[7:0];
   wire wrLow = busReq && wbWeI && wbSelI[0];
   wire rdReq = busReq && !wbWeI;
   wire hitCtrl = regOff == tag_exchange_pkg::OFF_CTRL;
   wire hitIrq0 = regOff == tag_exchange_pkg::OFF_IRQ0;
   wire hitIrq1 = regOff == tag_exchange_pkg::OFF_IRQ1;
   wire hitBuf = regOff == tag_exchange_pkg::OFF_BUFDATA;
   wire hitCmd = regOff == tag_exchange_pkg::OFF_CMD;
   wire hitEe = regOff == tag_exchange_pkg::OFF_EEREQ;

   logic arbit_reg;
   logic [7:0] irq0_reg, irq1_reg;
   logic ovf_reg, unf_reg;
   logic [tag_exchange_pkg::PTR_W-1:0] wrPtr_reg, rdPtr_reg;
   logic [tag_exchange_pkg::CNT_W-1:0] count_reg;
   tag_exchange_pkg::owner_t owner_reg, owner_next;
   logic initDone_reg, pullCfg_reg;
   logic eeBusy_reg, eeHost_reg, eeHostWr_reg;
   logic txPend_reg;
   logic [7:0] bufRData;

   // ----------------------------------------
   // ownership grant
   // ----------------------------------------
   // host buffer data accesses are single-cycle, so the host never holds the buffer
   wire hostBufWr = wrLow && hitBuf;
   wire hostBufRd = rdReq && hitBuf;
   wire hostBufAcc = hostBufWr || hostBufRd;
   wire ownIdle = owner_reg == tag_exchange_pkg::OWN_IDLE;
   wire hostGrant = hostBufAcc && ownIdle && !rfRx.start;
   wire accConflict = hostBufAcc && !hostGrant;
   wire cmdClear = wrLow && hitCmd && wbDatI[7:0] == tag_exchange_pkg::CMD_CLEAR_BUF;
   wire cmdTx = wrLow && hitCmd && wbDatI[7:0] == tag_exchange_pkg::CMD_TRANSMIT;
   wire rxByteOk = owner_reg == tag_exchange_pkg::OWN_RX && rfRx.valid;
   wire parityOk = ^rfRx.data == 1'b1;
   wire isFull = count_reg == tag_exchange_pkg::BUF_FULL;
   wire isEmpty = count_reg == '0;
   wire rxStore = rxByteOk && parityOk && !isFull;
   wire rxOvf = rxByteOk && isFull;
   wire hostStore = hostGrant && hostBufWr && !isFull;
   wire hostOvf = hostGrant && hostBufWr && isFull;
   wire hostUnf = hostGrant && hostBufRd && isEmpty;
   // one byte in flight: the next pop waits for the rf handshake
   wire txPop = owner_reg == tag_exchange_pkg::OWN_TX && !txPend_reg && !rfTxValid && !isEmpty;
   wire txDone = owner_reg == tag_exchange_pkg::OWN_TX && !txPend_reg && isEmpty;
   wire doPop = txPop || (hostGrant && hostBufRd && !isEmpty);
   wire doPush = rxStore || hostStore;
   // rf bit b1 arrives first and lands in D0
   wire [7:0] rxByte = rfRx.data[7:0];

   always_comb begin
      owner_next = owner_reg;
      unique case (owner_reg)
         tag_exchange_pkg::OWN_IDLE: begin
            if (rfRx.start) begin
               owner_next = tag_exchange_pkg::OWN_RX;
            end else if (cmdTx) begin
               owner_next = tag_exchange_pkg::OWN_TX;
            end
         end
         tag_exchange_pkg::OWN_RX: begin
            if (rfRx.stop) begin
               owner_next = tag_exchange_pkg::OWN_IDLE;
            end
         end
         tag_exchange_pkg::OWN_TX: begin
            if (txDone && !rfTxValid) begin
               owner_next = tag_exchange_pkg::OWN_IDLE;
            end
         end
         default: owner_next = tag_exchange_pkg::OWN_IDLE;
      endcase
   end

   byte_store store (
      .clk(clk),
      .we(doPush),
      .wAddr(wrPtr_reg),
      .wData(rxStore ? rxByte : wbDatI[7:0]),
      .rAddr(rdPtr_reg),
      .rData(bufRData)
   );

   // ----------------------------------------
   // buffer pointers and flags
   // ----------------------------------------
   wire rxBegin = ownIdle && rfRx.start;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         owner_reg <= tag_exchange_pkg::OWN_IDLE;
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
         ovf_reg <= 1'b0;
         unf_reg <= 1'b0;
      end else begin
         owner_reg <= owner_next;
         if (rxBegin || cmdClear) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
            ovf_reg <= 1'b0;
            unf_reg <= 1'b0;
         end else begin
            if (doPush) begin
               wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (doPop) begin
               rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            count_reg <= count_reg + {5'h00, doPush} - {5'h00, doPop};
         end
         // an error in the clearing cycle survives the clear
         if (rxOvf || hostOvf) begin
            ovf_reg <= 1'b1;
         end
         if (hostUnf) begin
            unf_reg <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // rf transmit path
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         txPend_reg <= 1'b0;
         rfTxValid <= 1'b0;
         rfTxData <= '0;
      end else begin
         txPend_reg <= txPop;
         if (txPend_reg) begin
            rfTxValid <= 1'b1;
            rfTxData <= {~^bufRData, bufRData};
         end else if (rfTxValid && rfTxReady) begin
            rfTxValid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // eeprom arbitration
   // ----------------------------------------
   // arbit 0: first come first served; arbit 1: rf aborts a running host job
   wire hostEeReq = wrLow && hitEe;
   wire eeAddrOk = wbDatI[15:8] <= 8'h7f;
   wire rfWins = rfEeReq && (!eeBusy_reg || (arbit_reg && eeHost_reg));
   wire hostEeGrant = hostEeReq && !eeBusy_reg && !rfEeReq && eeAddrOk;
   wire eeConflict = hostEeReq && (eeBusy_reg || rfEeReq);
   wire eeBadAddr = hostEeReq && !eeAddrOk && !eeConflict;
   wire eeAbort = rfWins && eeBusy_reg && eeHost_reg;
   wire hostEeEnd = eeBusy_reg && eeHost_reg && eeStat.ack;
   wire eeWrDone = hostEeEnd && eeHostWr_reg && !eeStat.fail;
   wire eeErr = (hostEeEnd && eeStat.fail) || eeAbort || eeBadAddr;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         eeBusy_reg <= 1'b0;
         eeHost_reg <= 1'b0;
         eeHostWr_reg <= 1'b0;
         rfEeGrant <= 1'b0;
         eeReq <= 1'b0;
         eeWrite <= 1'b0;
         eeAddr <= '0;
         eeWData <= '0;
      end else begin
         eeReq <= 1'b0;
         if (rfWins) begin
            eeBusy_reg <= 1'b1;
            eeHost_reg <= 1'b0;
            rfEeGrant <= 1'b1;
         end else if (hostEeGrant) begin
            eeBusy_reg <= 1'b1;
            eeHost_reg <= 1'b1;
            eeHostWr_reg <= wbDatI[0];
            eeReq <= 1'b1;
            eeWrite <= wbDatI[0];
            eeAddr <= wbDatI[14:8];
            eeWData <= {wbDatI[31:16], 16'h0000};
         end else if (eeStat.ack) begin
            eeBusy_reg <= 1'b0;
            rfEeGrant <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // interrupt registers
   // ----------------------------------------
   wire [7:0] irq0Set = {5'h00, txDone && !rfTxValid && owner_reg == owner_next ? 1'b0 :
      owner_reg == tag_exchange_pkg::OWN_TX && owner_next == tag_exchange_pkg::OWN_IDLE,
      owner_reg == tag_exchange_pkg::OWN_RX && rfRx.stop, rxBegin};
   wire [7:0] irq1Set = {4'h0, eeErr, eeWrDone, accConflict || eeConflict,
      rxOvf || hostOvf || hostUnf};
   wire rdIrq0 = rdReq && hitIrq0;
   wire rdIrq1 = rdReq && hitIrq1;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         irq0_reg <= tag_exchange_pkg::IRQ_RESET;
         irq1_reg <= tag_exchange_pkg::IRQ_RESET;
         irqOut <= 1'b0;
      end else begin
         // a new event in the clearing cycle survives the clear
         irq0_reg <= (rdIrq0 ? 8'h00 : irq0_reg) | irq0Set;
         irq1_reg <= (rdIrq1 ? 8'h00 : irq1_reg) | irq1Set;
         irqOut <= |(((rdIrq0 ? 8'h00 : irq0_reg) | irq0Set) |
            ((rdIrq1 ? 8'h00 : irq1_reg) | irq1Set));
      end
   end

   // ----------------------------------------
   // pull control and control register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         initDone_reg <= 1'b0;
         pullCfg_reg <= 1'b0;
         strongPullEn <= 1'b1;
         weakPullEn <= 1'b1;
         arbit_reg <= tag_exchange_pkg::CTRL_ARBIT_RESET;
      end else begin
         if (!initDone_reg && !selectN) begin
            initDone_reg <= 1'b1;
            pullCfg_reg <= factory_config_word[tag_exchange_pkg::FAB_PULLUP_BIT];
         end
         // before select falls both pulls are on
         strongPullEn <= initDone_reg ? pullCfg_reg : 1'b1;
         weakPullEn <= !initDone_reg;
         if (wrLow && hitCtrl) begin
            arbit_reg <= wbDatI[tag_exchange_pkg::CTRL_ARBIT_BIT];
         end
      end
   end

   // ----------------------------------------
   // bus answer
   // ----------------------------------------
   // buffer data read answers one cycle late because the store has registered output
   logic [31:0] rdMux;
   always_comb begin
      rdMux = 32'h0000_0000;
      unique case (regOff)
         tag_exchange_pkg::OFF_CTRL: rdMux = {31'h0, arbit_reg};
         tag_exchange_pkg::OFF_IRQ0: rdMux = {24'h0, irq0_reg};
         tag_exchange_pkg::OFF_IRQ1: rdMux = {24'h0, irq1_reg};
         tag_exchange_pkg::OFF_BSTAT2: rdMux = {26'h0, count_reg};
         tag_exchange_pkg::OFF_BSTAT1: rdMux = {30'h0, unf_reg, ovf_reg};
         tag_exchange_pkg::OFF_EEREQ: rdMux = {30'h0, eeBusy_reg, rfEeGrant};
         tag_exchange_pkg::OFF_PINS: rdMux = {29'h0, pullCfg_reg, weakPullEn, strongPullEn};
         default: rdMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         wbAckO <= 1'b0;
         wbDatO <= '0;
         bufRdPend_reg <= 1'b0;
      end else begin
         bufRdPend_reg <= hostGrant && hostBufRd && !isEmpty;
         if (bufRdPend_reg) begin
            wbAckO <= 1'b1;
            wbDatO <= {24'h0, bufRData};
         end else if (busReq && !hostGrant) begin
            wbAckO <= 1'b1;
            wbDatO <= rdMux;
         end else if (busReq && hostGrant && !(hostBufRd && !isEmpty)) begin
            wbAckO <= 1'b1;
            wbDatO <= 32'h0;
         end else begin
            wbAckO <= 1'b0;
         end
      end
   end
endmodule : tag_host_buffer

// File: tag_exchange_pkg.sv
// tag exchange package: constants, register offsets and carrier structs for the tag host buffer
// assumes a 32-bit classic wishbone master and a single 50 MHz clock
package tag_exchange_pkg;

   // ----------------------------------------
   // buffer geometry
   // ----------------------------------------
   localparam int BUF_DEPTH = 32;
   localparam int PTR_W = 5;
   localparam int CNT_W = 6;
   localparam logic [CNT_W-1:0] BUF_FULL = 6'h20;

   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_IRQ0 = 8'h04;
   localparam logic [7:0] OFF_IRQ1 = 8'h08;
   localparam logic [7:0] OFF_BSTAT2 = 8'h0c;
   localparam logic [7:0] OFF_BSTAT1 = 8'h10;
   localparam logic [7:0] OFF_BUFDATA = 8'h14;
   localparam logic [7:0] OFF_CMD = 8'h18;
   localparam logic [7:0] OFF_EEREQ = 8'h1c;
   localparam logic [7:0] OFF_PINS = 8'h20;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CTRL_ARBIT_BIT = 0;
   localparam int FAB_PULLUP_BIT = 5;
   localparam int IRQ0_RXS = 0;
   localparam int IRQ0_RXE = 1;
   localparam int IRQ0_TXE = 2;
   localparam int IRQ1_BUF_ERR = 0;
   localparam int IRQ1_ACC_ERR = 1;
   localparam int IRQ1_EEWR = 2;
   localparam int IRQ1_EEAC_ERR = 3;
   localparam int BST1_OVF = 0;
   localparam int BST1_UNF = 1;
   localparam logic [7:0] CMD_CLEAR_BUF = 8'hc4;
   localparam logic [7:0] CMD_TRANSMIT = 8'hc8;
   localparam int EE_ADDR_W = 7;

   // ----------------------------------------
   // reset values and timing
   // ----------------------------------------
   localparam logic [7:0] IRQ_RESET = 8'h00;
   localparam logic CTRL_ARBIT_RESET = 1'b0;
   localparam int CLK_HZ = 50000000;
   localparam int EE_PROG_US = 9500;
   localparam int EE_PROG_CYC = EE_PROG_US * (CLK_HZ / 1000000);

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic valid;
      logic [8:0] data;
      logic start;
      logic stop;
   } rf_rx_t;

   typedef struct packed {
      logic ready;
      logic ack;
      logic fail;
   } ee_status_t;

   typedef enum logic [3:0] {
      OWN_IDLE = 4'b0001,
      OWN_RX = 4'b0010,
      OWN_TX = 4'b0100,
      OWN_HOST = 4'b1000
   } owner_t;

endpackage : tag_exchange_pkg

// File: byte_store.sv
// byte_store: 32-entry byte memory with registered read data
// assumes one write and one read port, both in the clk domain
`timescale 1ns/1ps
module byte_store (
   input wire logic clk,
   input wire logic we,
   input wire logic [tag_exchange_pkg::PTR_W-1:0] wAddr,
   input wire logic [7:0] wData,
   input wire logic [tag_exchange_pkg::PTR_W-1:0] rAddr,
   output logic [7:0] rData
);
   logic [7:0] mem [tag_exchange_pkg::BUF_DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[wAddr] <= wData;
      end
      rData <= mem[rAddr];
   end
endmodule : byte_store

// File: tag_host_buffer_checker.sv
// tag_host_buffer_checker: port-level assertions for the tag host buffer
// assumes one clk domain with synchronous active-low nrst
`timescale 1ns/1ps
module tag_host_buffer_checker (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [31:0] wbAdrI,
   input wire logic wbWeI,
   input wire logic wbCycI,
   input wire logic wbStbI,
   input wire logic wbAckO,
   input wire logic [7:0] factory_config_word,
   input wire logic selectN,
   input wire logic strongPullEn,
   input wire logic weakPullEn,
   input wire logic irqOut,
   input wire logic rfTxReady,
   input wire logic rfTxValid,
   input wire logic [8:0] rfTxData,
   input wire logic rfEeGrant,
   input wire logic eeReq,
   input wire logic [tag_exchange_pkg::EE_ADDR_W-1:0] eeAddr
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   wire logic irqRd = wbCycI && wbStbI && !wbWeI && (wbAdrI[7:0] == tag_exchange_pkg::OFF_IRQ0
      || wbAdrI[7:0] == tag_exchange_pkg::OFF_IRQ1);

   a_ack_single: assert property (wbAckO |=> !wbAckO)
      else $error("ack held longer than one cycle");
   a_ack_cause: assert property (wbAckO |-> $past(wbCycI && wbStbI))
      else $error("ack without a request");
   a_init_pulls: assert property (weakPullEn |-> strongPullEn)
      else $error("strong pulls off during init");
   a_weak_drop: assert property (!selectN |-> ##[1:3] !weakPullEn)
      else $error("weak pull kept after select low");
   a_strong_cfg: assert property (!weakPullEn |->
      strongPullEn == factory_config_word[tag_exchange_pkg::FAB_PULLUP_BIT])
      else $error("strong pulls disagree with config bit");
   // irq may only fall right after an interrupt register read
   a_irq_clear: assert property ($fell(irqOut) |-> $past(irqRd) || $past(irqRd, 2))
      else $error("irq fell without a read");
   a_ee_pulse: assert property (eeReq |=> !eeReq)
      else $error("eeprom request longer than one cycle");
   a_ee_steady: assert property (eeReq |=> $stable(eeAddr) [*2])
      else $error("eeprom address moved during job");
   a_grant_excl: assert property (!(rfEeGrant && eeReq))
      else $error("host job issued while rf holds eeprom");
   a_tx_hold: assert property (rfTxValid && !rfTxReady |=> rfTxValid && $stable(rfTxData))
      else $error("tx byte dropped while stalled");
   a_tx_parity: assert property (rfTxValid |-> ^rfTxData)
      else $error("tx parity not odd");
   cover property ($rose(irqOut));
   cover property (rfTxValid && rfTxReady);
   cover property (eeReq);
endmodule : tag_host_buffer_checker

bind tag_host_buffer tag_host_buffer_checker chk_i (.clk, .nrst, .wbAdrI, .wbWeI, .wbCycI,
   .wbStbI, .wbAckO, .factory_config_word, .selectN, .strongPullEn, .weakPullEn, .irqOut,
   .rfTxReady, .rfTxValid, .rfTxData, .rfEeGrant, .eeReq, .eeAddr);

// File: ee_partner.sv
// ee_partner: behavioural eeprom controller answering host and rf jobs
// assumes jobs start on eeReq or a rising rf grant; fail only when commanded
`timescale 1ns/1ps
module ee_partner #(
   parameter int DELAY = 6
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic eeReq,
   input wire logic rfEeGrant,
   input wire logic failMode,
   output tag_exchange_pkg::ee_status_t eeStat
);
   int cnt;
   logic grantSeen;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cnt <= 0;
         grantSeen <= 1'b0;
         eeStat <= '0;
      end else begin
         grantSeen <= rfEeGrant;
         eeStat.ready <= (cnt == 0);
         eeStat.ack <= (cnt == 1);
         eeStat.fail <= (cnt == 1) && failMode;
         if (eeReq || (rfEeGrant && !grantSeen)) begin
            cnt <= DELAY;
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule : ee_partner

// File: tag_host_buffer_tb.sv
// tag_host_buffer_tb: wishbone-driven checks of buffer, interrupts, pulls and eeprom jobs
// assumes ee_partner as eeprom controller; the bench plays rf engine and host
`timescale 1ns/1ps
module tag_host_buffer_tb;
   logic clk, nrst, selectN, wbWeI, wbCycI, wbStbI, wbAckO, rfTxReady, rfEeReq, rfEeWrite;
   logic strongPullEn, weakPullEn, irqOut, rfTxValid, rfEeGrant, eeReq, eeWrite, failMode;
   logic [31:0] wbAdrI, wbDatI, wbDatO, eeWData, rdData, lastData;
   logic [3:0] wbSelI;
   logic [7:0] cfg;
   logic [8:0] rfTxData;
   logic [6:0] eeAddr, lastAddr;
   tag_exchange_pkg::rf_rx_t rfRx;
   tag_exchange_pkg::ee_status_t eeStat;
   int bad_count, tests_run;

   tag_host_buffer tag_host_buffer_i (.clk, .nrst, .wbAdrI, .wbDatI, .wbDatO, .wbWeI, .wbSelI,
      .wbCycI, .wbStbI, .wbAckO, .factory_config_word(cfg), .selectN, .strongPullEn,
      .weakPullEn, .irqOut, .rfRx, .rfTxReady, .rfTxValid, .rfTxData, .rfEeReq, .rfEeWrite,
      .rfEeGrant, .eeReq, .eeWrite, .eeAddr, .eeWData, .eeStat);
   ee_partner ee_partner_i (.clk, .nrst, .eeReq, .rfEeGrant, .failMode, .eeStat);

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // the eeprom request is a one-cycle pulse, so it is captured as it passes
   always @(posedge clk) if (eeReq === 1'b1) begin
      lastAddr <= eeAddr;
      lastData <= eeWData;
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic bus(input logic [7:0] adr, input logic we, input logic [31:0] wd);
      int n;
      wbAdrI <= {24'h0, adr};
      wbWeI <= we;
      wbDatI <= wd;
      wbCycI <= 1'b1;
      wbStbI <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wbAckO !== 1'b1 && n < 50);
      rdData = wbDatO;
      wbCycI <= 1'b0;
      wbStbI <= 1'b0;
      if (n >= 50) begin
         chk(32'h0, 32'h1, "bus timeout");
         test_done();
      end
      @(posedge clk);
   endtask : bus
   task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input string m);
      bus(adr, 1'b0, 32'h0);
      chk(rdData, exp, m);
   endtask : rd
   // which: 0 tx valid, 1 eeprom ack, 2 rf grant
   task automatic waitSig(input int which);
      int n;
      n = 0;
      while (n < 200 && !(which == 0 ? rfTxValid === 1'b1 : which == 1 ? eeStat.ack === 1'b1
            : rfEeGrant === 1'b1)) begin
         @(posedge clk);
         n++;
      end
      if (n >= 200) begin
         chk(32'h0, 32'h1, "wait timeout");
         test_done();
      end
   endtask : waitSig
   task automatic rx(input logic [8:0] d);
      rfRx <= {1'b1, d, 2'b00};
      @(posedge clk);
      rfRx <= '0;
      @(posedge clk);
   endtask : rx
   function automatic logic [8:0] par(input logic [7:0] b);
      return {~^b, b};
   endfunction : par

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {nrst, wbWeI, wbCycI, wbStbI, rfTxReady, rfEeReq, rfEeWrite, failMode} = '0;
      {wbAdrI, wbDatI, cfg, rfRx} = '0;
      wbSelI = 4'hf;
      selectN = 1'b1;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      chk(32'(strongPullEn & weakPullEn), 32'h1, "init pulls");
      selectN <= 1'b0;
      repeat (4) @(posedge clk);
      chk(32'({strongPullEn, weakPullEn}), 32'h0, "pulls off");
      nrst <= 1'b0;
      selectN <= 1'b1;
      cfg <= 8'h20;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      selectN <= 1'b0;
      repeat (4) @(posedge clk);
      chk(32'({strongPullEn, weakPullEn}), 32'h2, "pulls per config");
      rd(tag_exchange_pkg::OFF_PINS, 32'h5, "pin status");
      $display("test pulls done");
      bus(tag_exchange_pkg::OFF_CMD, 1'b1, 32'hc4);
      for (int i = 0; i < 3; i++) bus(tag_exchange_pkg::OFF_BUFDATA, 1'b1, 32'h10 + 32'(i));
      rd(tag_exchange_pkg::OFF_BSTAT2, 32'h3, "count");
      rd(tag_exchange_pkg::OFF_BUFDATA, 32'h10, "first byte");
      rd(tag_exchange_pkg::OFF_BSTAT2, 32'h2, "count after read");
      bus(tag_exchange_pkg::OFF_CMD, 1'b1, 32'hc4);
      rd(tag_exchange_pkg::OFF_BSTAT2, 32'h0, "cleared count");
      for (int i = 0; i < 33; i++) bus(tag_exchange_pkg::OFF_BUFDATA, 1'b1, 32'(i));
      rd(tag_exchange_pkg::OFF_BSTAT2, 32'h20, "full count");
      rd(tag_exchange_pkg::OFF_IRQ1, 32'h1, "overflow irq");
      rd(tag_exchange_pkg::OFF_BSTAT1, 32'h1, "overflow flag");
      chk(32'(irqOut), 32'h0, "irq after read");
      rd(tag_exchange_pkg::OFF_IRQ1, 32'h0, "irq1 cleared");
      bus(tag_exchange_pkg::OFF_CMD, 1'b1, 32'hc4);
      rd(tag_exchange_pkg::OFF_BSTAT1, 32'h0, "flags cleared");
      bus(tag_exchange_pkg::OFF_BUFDATA, 1'b0, 32'h0);
      rd(tag_exchange_pkg::OFF_BSTAT1, 32'h2, "underflow flag");
      rd(tag_exchange_pkg::OFF_IRQ1, 32'h1, "underflow irq");
      $display("test buffer done");
      bus(tag_exchange_pkg::OFF_BUFDATA, 1'b1, 32'hee);
      rfRx <= {1'b0, 9'h0, 2'b10};
      @(posedge clk);
      rfRx <= '0;
      repeat (2) @(posedge clk);
      chk(32'(irqOut), 32'h1, "irq on rx start");
      rx(par(8'ha5));
      rx({^8'h3c, 8'h3c});
      rx(par(8'h01));
      rd(tag_exchange_pkg::OFF_BUFDATA, 32'h0, "read while rf owns");
      rfRx <= {1'b0, 9'h0, 2'b01};
      @(posedge clk);
      rfRx <= '0;
      rd(tag_exchange_pkg::OFF_IRQ0, 32'h3, "rx irqs");
      rd(tag_exchange_pkg::OFF_IRQ1, 32'h2, "conflict irq");
      rd(tag_exchange_pkg::OFF_BSTAT2, 32'h2, "rx count");
      rd(tag_exchange_pkg::OFF_BUFDATA, 32'ha5, "rx byte");
      rd(tag_exchange_pkg::OFF_BUFDATA, 32'h01, "rx byte after bad");
      $display("test receive done");
      bus(tag_exchange_pkg::OFF_CMD, 1'b1, 32'hc4);
      bus(tag_exchange_pkg::OFF_BUFDATA, 1'b1, 32'h80);
      bus(tag_exchange_pkg::OFF_BUFDATA, 1'b1, 32'h07);
      bus(tag_exchange_pkg::OFF_CMD, 1'b1, 32'hc8);
      for (int i = 0; i < 2; i++) begin
         waitSig(0);
         repeat (2) @(posedge clk);
         chk(32'(rfTxData), 32'(par(i == 0 ? 8'h80 : 8'h07)), "tx byte");
         rfTxReady <= 1'b1;
         @(posedge clk);
         rfTxReady <= 1'b0;
         @(posedge clk);
      end
      repeat (3) @(posedge clk);
      rd(tag_exchange_pkg::OFF_IRQ0, 32'h4, "tx end irq");
      $display("test transmit done");
      // the bench host is taken to run on its own supply around eeprom jobs
      bus(tag_exchange_pkg::OFF_EEREQ, 1'b1, 32'h1234_7f01);
      bus(tag_exchange_pkg::OFF_EEREQ, 1'b1, 32'h0000_1001);
      chk({25'h0, lastAddr}, 32'h7f, "ee address");
      chk(lastData & 32'hffff_0000, 32'h1234_0000, "ee data");
      chk(32'(eeWrite), 32'h1, "ee write flag");
      waitSig(1);
      repeat (2) @(posedge clk);
      rd(tag_exchange_pkg::OFF_IRQ1, 32'h6, "ee done and busy");
      bus(tag_exchange_pkg::OFF_EEREQ, 1'b1, 32'h0000_8001);
      rd(tag_exchange_pkg::OFF_IRQ1, 32'h8, "bad ee address");
      failMode <= 1'b1;
      bus(tag_exchange_pkg::OFF_EEREQ, 1'b1, 32'h0005_0001);
      waitSig(1);
      repeat (2) @(posedge clk);
      rd(tag_exchange_pkg::OFF_IRQ1, 32'h8, "ee job failed");
      rfEeReq <= 1'b1;
      rfEeWrite <= 1'b1;
      waitSig(2);
      chk(32'(rfEeGrant), 32'h1, "rf grant");
      waitSig(1);
      rfEeReq <= 1'b0;
      // rf priority mode: a running host job is aborted when rf asks
      bus(tag_exchange_pkg::OFF_CTRL, 1'b1, 32'h1);
      rd(tag_exchange_pkg::OFF_CTRL, 32'h1, "arbit mode");
      bus(tag_exchange_pkg::OFF_EEREQ, 1'b1, 32'h0000_2001);
      rfEeReq <= 1'b1;
      waitSig(2);
      rd(tag_exchange_pkg::OFF_EEREQ, 32'h3, "rf took eeprom");
      waitSig(1);
      rfEeReq <= 1'b0;
      rd(tag_exchange_pkg::OFF_IRQ1, 32'h8, "host job aborted");
      $display("test eeprom done");
      test_done();
   end
endmodule : tag_host_buffer_tb
